// ==== pkg/nvram_defines.svh ====
// Constants for the serial nonvolatile SRAM store and recall controller
`ifndef NVRAM_DEFINES_SVH
`define NVRAM_DEFINES_SVH

`define SYS_CLK_MHZ 50

// Opcodes handled by this block
`define OPC_READ 8'h03
`define OPC_WRITE 8'h02
`define OPC_STORE 8'h3c
`define OPC_RECALL 8'h60
`define OPC_AUTO_SAVE_ON 8'h59
`define OPC_AUTO_SAVE_OFF 8'h19
// Opcodes decoded as valid but served elsewhere
`define OPC_WR_ENABLE 8'h06
`define OPC_WR_DISABLE 8'h04
`define OPC_RD_STATUS 8'h05
`define OPC_WR_STATUS 8'h01

// Times in ns
`define HW_STORE_START_DELAY_NS 25000
`define STORE_DURATION_NS 8000000
`define BUSY_RELEASE_DRIVE_TIME_NS 100
`define POST_STORE_ACCESS_DELAY_NS 5000
`define POWERUP_RECALL_DURATION_NS 20000000
`define SW_RECALL_DURATION_NS 200000

// Cycle counts, least times rounded up
`define HW_STORE_START_DELAY_CYC ((`HW_STORE_START_DELAY_NS * `SYS_CLK_MHZ + 999) / 1000)
`define STORE_DURATION_CYC ((`STORE_DURATION_NS * `SYS_CLK_MHZ + 999) / 1000)
`define BUSY_RELEASE_DRIVE_TIME_CYC ((`BUSY_RELEASE_DRIVE_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define POST_STORE_ACCESS_DELAY_CYC ((`POST_STORE_ACCESS_DELAY_NS * `SYS_CLK_MHZ + 999) / 1000)
`define POWERUP_RECALL_DURATION_CYC ((`POWERUP_RECALL_DURATION_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SW_RECALL_DURATION_CYC ((`SW_RECALL_DURATION_NS * `SYS_CLK_MHZ + 999) / 1000)
`define RECALL_CLEAR_CYC 16

// Geometry
`define ADDR_W 15
`define DATA_W 8
`define WR_FIFO_DEPTH 4

// Pin synchroniser order and reset levels: power_fail, busy pin, si, sck, cs_n
`define PIN_CNT 5
`define PIN_RST 5'h08
`define AUTO_SAVE_RST 1'b1

`endif

// ==== pkg/nvram_pkg.sv ====
// Types for the serial nonvolatile SRAM store and recall controller
`default_nettype none
package nvram_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_HW_WAIT = 3'b001,
    SEQ_STORE = 3'b010,
    SEQ_RELEASE = 3'b011,
    SEQ_POST = 3'b100,
    SEQ_RCL_CLEAR = 3'b101,
    SEQ_RCL_COPY = 3'b110
  } seq_state_t;

  typedef enum logic [1:0] {
    SPI_OPCODE = 2'b00,
    SPI_ADDR = 2'b01,
    SPI_DATA = 2'b10,
    SPI_IGNORE = 2'b11
  } spi_phase_t;

endpackage
`default_nettype wire

// ==== logic/nvram_store_recall_ctrl.sv ====
// SPI slave front end with store and recall sequencing for a serial nonvolatile SRAM
//
// Operation
// - Busy pin pulled low while idle starts conditional store after start delay.
// - Pin-requested store runs only if SRAM written since last store or recall.
// - Memory access blocked during store duration or while busy pin held low.
// - Busy pin pulled low, open drain, during every store.
// - After each store, busy pin driven high briefly, then released to pull-up.
// - Access stays blocked for post-store delay after busy pin returns high.
// - Recall clears SRAM, then copies nonvolatile data; access blocked throughout.
// - Power-up recall always runs, blocks access, signals busy on pin.
// - Recall instruction runs software recall for its duration, blocking access.
// - Auto-save off instruction disables power-down store; on instruction restores.
// - Auto-save setting volatile; persists only through a following store.
// - Delivered with auto-save on where hold-up capacitor exists; cells zero.
// - Instructions only while selected; deselected ignores input, output high impedance.
// - Instruction starts at select falling edge; one opcode per select period.
// - Input sampled on rising clock edges, output changed on falling edges.
// - Opcode, address and data shifted most significant bit first.
// - Two-byte address, low 15 bits used, first bit ignored.
// - First byte after select is the opcode; address and data follow.
// - Unknown opcode discarded; rest of select period ignored, output tristated.
// - Clock level at select picks mode 0 or mode 3.
// - Ready flag is one while store or software recall runs.
`timescale 1ns/1ps
`default_nettype none
`include "nvram_defines.svh"

module nvram_wr_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr - rd_ptr) != (PW + 1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = slot[rd_ptr[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module nvram_store_recall_ctrl
  import nvram_pkg::*;
#(
  parameter int unsigned STORE_CYC = `STORE_DURATION_CYC,
  parameter int unsigned PWRUP_RCL_CYC = `POWERUP_RECALL_DURATION_CYC,
  parameter int unsigned SW_RCL_CYC = `SW_RECALL_DURATION_CYC,
  parameter bit HAS_HOLDUP_CAP = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // SPI pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  // Store busy pin, open drain with driven-high release
  input wire logic hw_store_busy_pin_in,
  output logic hw_store_busy_pin_out,
  output logic hw_store_busy_pin_oe_n,
  // Supply monitor and saved auto-save setting
  input wire logic power_fail,
  input wire logic auto_save_nv,
  // SRAM array read port, data one cycle after enable
  output logic mem_rd_en,
  output logic [`ADDR_W-1:0] mem_rd_addr,
  input wire logic [`DATA_W-1:0] mem_rd_data,
  // SRAM array write port
  output logic mem_wr_en,
  output logic [`ADDR_W-1:0] mem_wr_addr,
  output logic [`DATA_W-1:0] mem_wr_data,
  input wire logic mem_wr_ready,
  // Nonvolatile array control
  output logic nv_store_run,
  output logic sram_clear_run,
  output logic nv_recall_run,
  // Status
  output logic ready_flag,
  output logic auto_save_on,
  output logic spi_mode3,
  output logic access_blocked,
  output logic write_overrun
);
  localparam int unsigned START_CYC = `HW_STORE_START_DELAY_CYC;
  localparam int unsigned RELEASE_CYC = `BUSY_RELEASE_DRIVE_TIME_CYC;
  localparam int unsigned POST_CYC = `POST_STORE_ACCESS_DELAY_CYC;
  localparam int unsigned CLEAR_CYC = `RECALL_CLEAR_CYC;
  localparam int FW = `ADDR_W + `DATA_W;

  // Pin synchronisers
  logic [`PIN_CNT-1:0] pin_raw;
  logic [`PIN_CNT-1:0] sync1;
  logic [`PIN_CNT-1:0] sync2;
  logic [`PIN_CNT-1:0] sync3;
  logic [`PIN_CNT-1:0] pin_s;
  logic [`PIN_CNT-1:0] pin_q;

  assign pin_raw = {power_fail, hw_store_busy_pin_in, si, sck, cs_n};

  generate
    for (genvar i = 0; i < `PIN_CNT; i++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          sync1[i] <= 1'(`PIN_RST >> i);
          sync2[i] <= 1'(`PIN_RST >> i);
          sync3[i] <= 1'(`PIN_RST >> i);
          pin_s[i] <= 1'(`PIN_RST >> i);
          pin_q[i] <= 1'(`PIN_RST >> i);
        end else begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          if (sync2[i] == sync3[i]) begin
            pin_s[i] <= sync3[i];
          end
          pin_q[i] <= pin_s[i];
        end
      end
    end
  endgenerate

  logic cs_fall;
  logic cs_high;
  logic sck_rise;
  logic sck_fall;
  logic si_s;
  logic busy_low;
  logic busy_fall;
  logic pf_rise;

  // cs_n sync resets low, so a select needs a seen high-to-low edge
  assign cs_fall = !pin_s[0] && pin_q[0];
  assign cs_high = pin_s[0];
  assign sck_rise = pin_s[1] && !pin_q[1];
  assign sck_fall = !pin_s[1] && pin_q[1];
  assign si_s = pin_s[2];
  assign busy_low = !pin_s[3];
  assign busy_fall = !pin_s[3] && pin_q[3];
  assign pf_rise = pin_s[4] && !pin_q[4];

  // SPI receive
  spi_phase_t phase;
  logic [2:0] bit_cnt;
  logic [`DATA_W-1:0] rx;
  logic [`DATA_W-1:0] next_byte;
  logic byte_done;
  logic is_read;
  logic addr_hi_done;
  logic [`ADDR_W-1:0] addr;
  logic blocked;
  seq_state_t state;
  logic store_pend;
  logic recall_pend;

  assign next_byte = {rx[`DATA_W-2:0], si_s};
  assign byte_done = sck_rise && bit_cnt == 3'h7 && phase != SPI_IGNORE && !cs_high;

  logic op_done;
  logic cmd_store;
  logic cmd_recall;
  logic cmd_save_on;
  logic cmd_save_off;
  logic opc_known;

  assign op_done = byte_done && phase == SPI_OPCODE;
  assign cmd_store = op_done && next_byte == `OPC_STORE;
  assign cmd_recall = op_done && next_byte == `OPC_RECALL;
  assign cmd_save_on = op_done && next_byte == `OPC_AUTO_SAVE_ON;
  assign cmd_save_off = op_done && next_byte == `OPC_AUTO_SAVE_OFF;
  assign opc_known = next_byte == `OPC_WR_ENABLE || next_byte == `OPC_WR_DISABLE ||
                     next_byte == `OPC_RD_STATUS || next_byte == `OPC_WR_STATUS;

  assign blocked = state != SEQ_IDLE || busy_low || store_pend || recall_pend;

  logic push_valid;
  logic push_ready;

  assign push_valid = byte_done && phase == SPI_DATA && !is_read && !blocked;

  // mode from clock level at select
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      spi_mode3 <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= pin_s[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      phase <= SPI_IGNORE;
      bit_cnt <= 3'h0;
      rx <= 8'h00;
      is_read <= 1'b0;
      addr_hi_done <= 1'b0;
      addr <= 15'h0000;
    end else if (cs_high) begin
      phase <= SPI_IGNORE;
    end else if (cs_fall) begin
      phase <= SPI_OPCODE;
      bit_cnt <= 3'h0;
      addr_hi_done <= 1'b0;
    end else if (sck_rise && phase != SPI_IGNORE) begin
      rx <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (phase)
          SPI_OPCODE: begin
            if ((next_byte == `OPC_READ || next_byte == `OPC_WRITE) && !blocked) begin
              phase <= SPI_ADDR;
              is_read <= next_byte == `OPC_READ;
            end else begin
              phase <= SPI_IGNORE;
            end
          end
          SPI_ADDR: begin
            if (!addr_hi_done) begin
              addr_hi_done <= 1'b1;
              addr <= {next_byte[6:0], 8'h00};
            end else begin
              addr <= {addr[14:8], next_byte};
              phase <= blocked ? SPI_IGNORE : SPI_DATA;
            end
          end
          SPI_DATA: begin
            if (blocked) begin
              phase <= SPI_IGNORE;
            end else begin
              addr <= addr + 15'h0001;
            end
          end
          default: phase <= SPI_IGNORE;
        endcase
      end
    end
  end

  // invalid opcode flag kept for visibility
  logic opc_invalid;
  assign opc_invalid = op_done && !opc_known && !cmd_store && !cmd_recall && !cmd_save_on &&
                       !cmd_save_off && next_byte != `OPC_READ && next_byte != `OPC_WRITE;

  // Read path
  logic rd_pend;
  logic [`DATA_W-1:0] rd_byte;
  logic [`DATA_W-1:0] tx_sh;
  logic [2:0] tx_cnt;
  logic reading;

  assign reading = phase == SPI_DATA && is_read;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mem_rd_en <= 1'b0;
      mem_rd_addr <= 15'h0000;
      rd_pend <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      mem_rd_en <= 1'b0;
      rd_pend <= mem_rd_en;
      if (rd_pend) begin
        rd_byte <= mem_rd_data;
      end
      if (byte_done && phase == SPI_ADDR && addr_hi_done && is_read && !blocked) begin
        mem_rd_en <= 1'b1;
        mem_rd_addr <= {addr[14:8], next_byte};
      end else if (reading && sck_fall && tx_cnt == 3'h0) begin
        // Prefetch next byte, wraps at top of array
        mem_rd_en <= 1'b1;
        mem_rd_addr <= mem_rd_addr + 15'h0001;
      end
    end
  end

  // output changes on falling edge, tristate otherwise
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
      tx_sh <= 8'h00;
      tx_cnt <= 3'h0;
    end else if (!reading || blocked) begin
      so_oe_n <= 1'b1;
      tx_cnt <= 3'h0;
    end else if (sck_fall) begin
      so_oe_n <= 1'b0;
      if (tx_cnt == 3'h0) begin
        so_out <= rd_byte[7];
        tx_sh <= {rd_byte[6:0], 1'b0};
        tx_cnt <= 3'h7;
      end else begin
        so_out <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
        tx_cnt <= tx_cnt - 3'h1;
      end
    end
  end

  // Write path: spaced pushes, drained at array pace
  logic fifo_valid;
  logic [FW-1:0] fifo_data;

  nvram_wr_fifo #(
    .WIDTH(FW),
    .DEPTH(`WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(sys_clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({addr, next_byte}),
    .out_valid(fifo_valid),
    .out_ready(mem_wr_ready),
    .out_data(fifo_data)
  );

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 15'h0000;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_en <= fifo_valid && mem_wr_ready;
      if (fifo_valid && mem_wr_ready) begin
        mem_wr_addr <= fifo_data[FW-1:`DATA_W];
        mem_wr_data <= fifo_data[`DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      write_overrun <= 1'b0;
    end else if (cs_fall) begin
      write_overrun <= 1'b0;
    end else if (push_valid && !push_ready) begin
      write_overrun <= 1'b1;
    end
  end

  // Written-since-copy flag
  logic dirty;
  logic copy_done;
  logic [31:0] cnt;
  logic pwrup;

  assign copy_done = (state == SEQ_STORE || state == SEQ_RCL_COPY) && cnt == 32'h0;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dirty <= 1'b0;
    end else if (fifo_valid && mem_wr_ready) begin
      dirty <= 1'b1;
    end else if (copy_done) begin
      dirty <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      auto_save_on <= HAS_HOLDUP_CAP ? `AUTO_SAVE_RST : 1'b0;
    end else if (HAS_HOLDUP_CAP) begin
      if (cmd_save_on) begin
        auto_save_on <= 1'b1;
      end else if (cmd_save_off) begin
        auto_save_on <= 1'b0;
      end else if (state == SEQ_RCL_COPY && cnt == 32'h0 && pwrup) begin
        auto_save_on <= auto_save_nv;
      end
    end
  end

  // Store and recall sequencer
  logic hw_go;
  logic auto_go;

  assign hw_go = state == SEQ_HW_WAIT && cnt == 32'h0 && dirty;
  assign auto_go = pf_rise && auto_save_on && dirty;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      store_pend <= 1'b0;
    end else if (cmd_store || hw_go || auto_go) begin
      store_pend <= 1'b1;
    end else if (state == SEQ_STORE) begin
      store_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      recall_pend <= 1'b0;
    end else if (cmd_recall) begin
      recall_pend <= 1'b1;
    end else if (state == SEQ_RCL_CLEAR) begin
      recall_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= SEQ_RCL_CLEAR;
      cnt <= CLEAR_CYC - 1;
      pwrup <= 1'b1;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (store_pend && !fifo_valid && !mem_wr_en) begin
            state <= SEQ_STORE;
            cnt <= STORE_CYC - 1;
          end else if (recall_pend) begin
            state <= SEQ_RCL_CLEAR;
            cnt <= CLEAR_CYC - 1;
            pwrup <= 1'b0;
          end else if (busy_fall) begin
            state <= SEQ_HW_WAIT;
            cnt <= START_CYC - 1;
          end
        end
        SEQ_HW_WAIT: begin
          if (cnt == 32'h0) begin
            state <= SEQ_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        SEQ_STORE: begin
          if (cnt == 32'h0) begin
            state <= SEQ_RELEASE;
            cnt <= RELEASE_CYC - 1;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        SEQ_RELEASE: begin
          if (cnt == 32'h0) begin
            state <= SEQ_POST;
            cnt <= POST_CYC - 1;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        SEQ_POST: begin
          // delay counts only once pin is high
          if (busy_low) begin
            cnt <= POST_CYC - 1;
          end else if (cnt == 32'h0) begin
            state <= SEQ_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        SEQ_RCL_CLEAR: begin
          if (cnt == 32'h0) begin
            state <= SEQ_RCL_COPY;
            cnt <= (pwrup ? PWRUP_RCL_CYC : SW_RCL_CYC) - CLEAR_CYC - 1;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        SEQ_RCL_COPY: begin
          if (cnt == 32'h0) begin
            state <= SEQ_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: begin
          state <= SEQ_IDLE;
          cnt <= 32'h0;
        end
      endcase
    end
  end

  // Registered status and pin drive, one cycle behind the sequencer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      nv_store_run <= 1'b0;
      sram_clear_run <= 1'b0;
      nv_recall_run <= 1'b0;
      ready_flag <= 1'b0;
      access_blocked <= 1'b1;
      hw_store_busy_pin_out <= 1'b0;
      hw_store_busy_pin_oe_n <= 1'b0;
    end else begin
      nv_store_run <= state == SEQ_STORE;
      sram_clear_run <= state == SEQ_RCL_CLEAR;
      nv_recall_run <= state == SEQ_RCL_COPY;
      ready_flag <= state == SEQ_STORE ||
                    (!pwrup && (state == SEQ_RCL_CLEAR || state == SEQ_RCL_COPY));
      access_blocked <= blocked;
      // pull low while busy; drive high after store
      hw_store_busy_pin_out <= state == SEQ_RELEASE;
      hw_store_busy_pin_oe_n <= !(state == SEQ_STORE || state == SEQ_RELEASE ||
                                  (pwrup && (state == SEQ_RCL_CLEAR || state == SEQ_RCL_COPY)));
    end
  end

endmodule
`default_nettype wire

// ==== dv/nvram_ctrl_monitor.sv ====
// Port-level checks for the store and recall controller
`timescale 1ns/1ps
`default_nettype none
module nvram_ctrl_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pins and status
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic hw_store_busy_pin_in,
  input wire logic hw_store_busy_pin_out,
  input wire logic hw_store_busy_pin_oe_n,
  input wire logic nv_store_run,
  input wire logic sram_clear_run,
  input wire logic nv_recall_run,
  input wire logic ready_flag,
  input wire logic access_blocked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] cs_hi;
  logic [8:0] pin_hi;
  logic stored;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !cs_n) cs_hi <= 4'h0;
    else if (cs_hi != 4'hf) cs_hi <= cs_hi + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn || !hw_store_busy_pin_in) pin_hi <= 9'h000;
    else if (pin_hi != 9'h1ff) pin_hi <= pin_hi + 9'h001;
  end
  // Marks a store whose access block has not yet ended
  always_ff @(posedge sys_clk) begin
    if (!rstn) stored <= 1'b0;
    else if (nv_store_run) stored <= 1'b1;
    else if (!access_blocked) stored <= 1'b0;
  end
  property p_store_low;
    nv_store_run [*2] |-> !hw_store_busy_pin_oe_n && !hw_store_busy_pin_out;
  endproperty
  a_store_low: assert property (p_store_low) else $error("busy pin not low in store");
  property p_release_high;
    $fell(nv_store_run) |-> ##[0:2] (!hw_store_busy_pin_oe_n && hw_store_busy_pin_out);
  endproperty
  a_release_high: assert property (p_release_high) else $error("busy pin not driven high");
  property p_release_len;
    $rose(!hw_store_busy_pin_oe_n && hw_store_busy_pin_out) |->
      (!hw_store_busy_pin_oe_n && hw_store_busy_pin_out) [*4] ##[1:2] hw_store_busy_pin_oe_n;
  endproperty
  a_release_len: assert property (p_release_len) else $error("busy release drive wrong length");
  property p_ready;
    nv_store_run [*2] |-> ready_flag;
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag low in store");
  property p_clear_copy;
    $fell(sram_clear_run) |-> ##[0:1] nv_recall_run;
  endproperty
  a_clear_copy: assert property (p_clear_copy) else $error("copy does not follow clear");
  property p_blocked;
    (nv_store_run || sram_clear_run || nv_recall_run) [*2] |-> access_blocked;
  endproperty
  a_blocked: assert property (p_blocked) else $error("access open during copy");
  property p_powerup;
    $rose(rstn) |-> ##[0:2] (sram_clear_run && !hw_store_busy_pin_oe_n);
  endproperty
  a_powerup: assert property (p_powerup) else $error("no power-up recall");
  property p_desel;
    cs_hi == 4'h8 |-> so_oe_n;
  endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  property p_post;
    $fell(access_blocked) && stored |-> pin_hi >= 9'h0fa;
  endproperty
  a_post: assert property (p_post) else $error("access reopened early after store");
  property p_pin_block;
    !hw_store_busy_pin_in [*6] |-> access_blocked;
  endproperty
  a_pin_block: assert property (p_pin_block) else $error("access open while busy pin low");
endmodule
bind nvram_store_recall_ctrl nvram_ctrl_monitor u_mon (.sys_clk, .rstn, .cs_n, .so_oe_n,
  .hw_store_busy_pin_in, .hw_store_busy_pin_out, .hw_store_busy_pin_oe_n, .nv_store_run,
  .sram_clear_run, .nv_recall_run, .ready_flag, .access_blocked);
`default_nettype wire

// ==== dv/spi_master_model.sv ====
// SPI bus master model for the serial pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_line
);
  logic idle_hi;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    idle_hi = 1'b0;
  end
  task automatic open_frame(input logic mode3);
    sck = mode3;
    idle_hi = mode3;
    #200 cs_n = 1'b0;
    #200;
  endtask
  // msb first, change low, sample late in high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      #80 sck = 1'b1;
      #70 rx[i] = so_line;
      #10;
    end
  endtask
  // deselect between instructions; clock stands still
  task automatic close_frame();
    #80 sck = idle_hi;
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the store and recall controller
`timescale 1ns/1ps
`default_nettype none
`include "nvram_defines.svh"
module testbench;
  import nvram_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sck, si, so_out, so_oe_n, so_alt = 1'b0, pull_low = 1'b0, quiet = 1'b0;
  logic hw_store_busy_pin_out, hw_store_busy_pin_oe_n, power_fail = 1'b0, auto_save_nv = 1'b1;
  logic mem_rd_en, mem_wr_en, mem_wr_ready = 1'b1, nv_store_run, sram_clear_run, nv_recall_run;
  logic ready_flag, auto_save_on, spi_mode3, access_blocked, write_overrun;
  logic [`ADDR_W-1:0] mem_rd_addr, mem_wr_addr;
  logic [`DATA_W-1:0] mem_rd_data = 8'h00, mem_wr_data;
  logic [`DATA_W-1:0] mem [0:32767];
  logic [71:0] rxv;
  logic [47:0] d;
  logic [23:0] exp_q[$];
  int bad_count = 0, n_checks = 0;
  // Weak pull-up unless someone pulls low
  wire logic hw_store_busy_pin_in = !hw_store_busy_pin_oe_n ? hw_store_busy_pin_out : !pull_low;
  wire logic so_line = so_oe_n ? so_alt : so_out;
  nvram_store_recall_ctrl #(.STORE_CYC(50), .PWRUP_RCL_CYC(40), .SW_RCL_CYC(60)) u_dut (.sys_clk, .rstn,
    .cs_n, .sck, .si, .so_out, .so_oe_n, .hw_store_busy_pin_in, .hw_store_busy_pin_out,
    .hw_store_busy_pin_oe_n, .power_fail, .auto_save_nv, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
    .mem_wr_en, .mem_wr_addr, .mem_wr_data, .mem_wr_ready, .nv_store_run, .sram_clear_run,
    .nv_recall_run, .ready_flag, .auto_save_on, .spi_mode3, .access_blocked, .write_overrun);
  spi_master_model u_master (.cs_n, .sck, .si, .so_line);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    so_alt <= ~so_alt;
    if (mem_rd_en) mem_rd_data <= mem[mem_rd_addr];
    if (mem_wr_en) mem[mem_wr_addr] <= mem_wr_data;
  end
  always @(posedge sys_clk) begin
    if (mem_wr_en === 1'b1) check({1'b1, mem_wr_addr, mem_wr_data}, pop());
    if (quiet) check({23'h0, so_oe_n}, 24'h1);
  end
  function automatic logic [23:0] pop();
    if (exp_q.size() == 0) return 24'hxxxxxx;
    return exp_q.pop_front();
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input logic m3, input int n, input logic [71:0] pk);
    logic [7:0] r;
    u_master.open_frame(m3);
    for (int i = 0; i < n; i++) begin
      u_master.xfer(pk[71-8*i -: 8], r);
      rxv[71-8*i -: 8] = r;
    end
    u_master.close_frame();
  endtask
  task automatic wr1(input logic [15:0] a, input logic [7:0] v);
    exp_q.push_back({1'b1, a[14:0], v});
    cmd(1'b0, 4, {`OPC_WRITE, a, v, 40'h0});
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 3000 && access_blocked !== 1'b0; k++) tick(1);
    check({23'h0, access_blocked}, 24'h0);
    tick(4);
  endtask
  task automatic expect_run(input logic sel, input int lim, input logic want);
    logic seen, rdy;
    seen = 1'b0;
    rdy = 1'b0;
    for (int k = 0; k < lim; k++) begin
      seen |= (sel ? nv_recall_run : nv_store_run) === 1'b1;
      rdy |= ready_flag === 1'b1;
      tick(1);
    end
    check({22'h0, seen, rdy}, {22'h0, want, want});
  endtask
  initial begin
    void'($urandom(32'h406e222f));
    d = 48'({$urandom, $urandom});
    tick(16);
    rstn = 1'b1;
    wait_idle();
    // Top address bit sent as one, burst wraps to zero
    for (int i = 0; i < 3; i++) exp_q.push_back({1'b1, 15'h7ffe + 15'(i), d[47-8*i -: 8]});
    cmd(1'b0, 6, {`OPC_WRITE, 16'hfffe, d[47:24], 24'h0});
    check({23'h0, spi_mode3}, 24'h0);
    cmd(1'b1, 6, {`OPC_READ, 16'h7ffe, 48'h0});
    for (int i = 0; i < 3; i++) check({16'h0, rxv[47-8*i -: 8]}, {16'h0, d[47-8*i -: 8]});
    check({23'h0, spi_mode3}, 24'h1);
    quiet = 1'b1;
    cmd(1'b0, 5, {8'h1e, `OPC_WRITE, 16'h0, 8'h55, 32'h0});
    quiet = 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr1(16'h0010, d[7:0]);
      cmd(1'b1, 1, {(i[0] ? `OPC_AUTO_SAVE_ON : `OPC_AUTO_SAVE_OFF), 64'h0});
      check({23'h0, auto_save_on}, {23'h0, i[0]});
      tick(1);
      power_fail = 1'b1;
      expect_run(1'b0, 300, i[0]);
      power_fail = 1'b0;
      wait_idle();
    end
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr1(16'h0020, d[15:8]);
      // request only after the last data bit
      tick(1);
      pull_low = 1'b1;
      tick(20);
      pull_low = 1'b0;
      // write refused while the request waits
      if (i == 0) cmd(1'b0, 4, {`OPC_WRITE, 16'h0030, d[23:16], 40'h0});
      expect_run(1'b0, 1400, i[0]);
      wait_idle();
    end
    cmd(1'b1, 1, {`OPC_STORE, 64'h0});
    expect_run(1'b0, 20, 1'b1);
    wait_idle();
    cmd(1'b0, 1, {`OPC_RECALL, 64'h0});
    expect_run(1'b1, 20, 1'b1);
    wait_idle();
    tick(1);
    mem_wr_ready = 1'b0;
    for (int i = 0; i < 4; i++) exp_q.push_back({1'b1, 15'h0100 + 15'(i), d[47-8*i -: 8]});
    cmd(1'b0, 9, {`OPC_WRITE, 16'h0100, d});
    check({23'h0, write_overrun}, 24'h1);
    tick(1);
    mem_wr_ready = 1'b1;
    tick(20);
    check(24'(exp_q.size()), 24'h0);
    close_out();
  end
  initial begin
    #1ms;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
